//--- design/acb_cond_eval.v
// branch condition evaluation from status flags
`include "acb_defines.vh"

module acb_cond_eval (
  // condition select
  input wire [7:0] cond_code,
  // comparison flags
  input wire null_result,
  input wire same_value,
  input wire greater_than,
  input wire less_than,
  // error flags
  input wire timeout_error_flag,
  input wire alarm_input_flag,
  input wire deviation_error_flag,
  input wire position_error_flag,
  // decision
  output reg take_branch
);

  always @* begin
    case (cond_code)
      `ACB_COND_NULL_RESULT: take_branch = null_result;
      `ACB_COND_NONNULL_RESULT: take_branch = !null_result;
      `ACB_COND_SAME_VALUE: take_branch = same_value;
      `ACB_COND_DIFFERS_VALUE: take_branch = !same_value;
      `ACB_COND_GREATER_THAN: take_branch = greater_than;
      `ACB_COND_GREATER_OR_SAME: take_branch = greater_than | same_value;
      `ACB_COND_LESS_THAN: take_branch = less_than;
      `ACB_COND_BELOW_OR_SAME: take_branch = less_than | same_value;
      `ACB_COND_TIMEOUT: take_branch = timeout_error_flag;
      `ACB_COND_ALARM: take_branch = alarm_input_flag;
      `ACB_COND_DEVIATION: take_branch = deviation_error_flag;
      `ACB_COND_POSITION: take_branch = position_error_flag;
      // unknown codes never branch
      default: take_branch = 1'b0;
    endcase
  end

endmodule // acb_cond_eval

//--- design/acb_divider.v
// signed iterative divider, quotient truncated toward zero
`include "acb_defines.vh"

module acb_divider (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // request
  input wire start,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  // result
  output reg done_ff,
  output reg [31:0] quotient_ff,
  output reg [31:0] remainder_ff
);

  reg busy_ff;
  reg [5:0] cnt_ff;
  reg [31:0] rem_ff;
  reg [31:0] quo_ff;
  reg [31:0] div_ff;
  reg neg_q_ff;
  reg neg_r_ff;

  wire [32:0] shifted = {rem_ff, quo_ff[31]};
  wire [32:0] trial = shifted - {1'b0, div_ff};
  wire fits = ~trial[32];
  wire [31:0] nxt_rem = fits ? trial[31:0] : shifted[31:0];
  wire [31:0] nxt_quo = {quo_ff[30:0], fits};

  always @(posedge ref_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 6'h00;
      rem_ff <= 32'h00000000;
      quo_ff <= 32'h00000000;
      div_ff <= 32'h00000000;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
      done_ff <= 1'b0;
      quotient_ff <= 32'h00000000;
      remainder_ff <= 32'h00000000;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        // work on magnitudes, fix signs at the end
        busy_ff <= 1'b1;
        cnt_ff <= `ACB_DIV_STEPS;
        rem_ff <= 32'h00000000;
        quo_ff <= dividend[31] ? (32'h00000000 - dividend) : dividend;
        div_ff <= divisor[31] ? (32'h00000000 - divisor) : divisor;
        neg_q_ff <= dividend[31] ^ divisor[31];
        neg_r_ff <= dividend[31];
      end else if (busy_ff) begin
        rem_ff <= nxt_rem;
        quo_ff <= nxt_quo;
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          quotient_ff <= neg_q_ff ? (32'h00000000 - nxt_quo) : nxt_quo;
          // remainder follows the sign of the dividend
          remainder_ff <= neg_r_ff ? (32'h00000000 - nxt_rem) : nxt_rem;
        end
      end
    end
  end

endmodule // acb_divider

//--- design/acb_unit.v
// accumulator, compare and conditional branch unit
`include "acb_defines.vh"

module acb_unit (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // command in
  input wire cmd_valid,
  output wire cmd_ready,
  input wire cmd_direct,
  input wire [7:0] cmd_opcode,
  input wire [7:0] cmd_type,
  input wire [7:0] cmd_bank,
  input wire [7:0] cmd_value_b3,
  input wire [7:0] cmd_value_b2,
  input wire [7:0] cmd_value_b1,
  input wire [7:0] cmd_value_b0,
  // reply out
  output reg rsp_valid_ff,
  output reg [7:0] rsp_status_ff,
  output reg [7:0] rsp_opcode_ff,
  output reg [31:0] rsp_value_ff,
  // accumulator load from other instructions
  input wire acc_load_valid,
  input wire [31:0] acc_load_data,
  // program counter and accumulator
  input wire pc_load_valid,
  input wire [31:0] pc_load_data,
  output reg [31:0] pc_ff,
  output reg [31:0] acc_ff,
  // error events and levels
  input wire wait_timeout,
  input wire error_clear,
  input wire alarm_in,
  input wire deviation_error,
  input wire position_error,
  // flag view
  output reg null_result_ff,
  output reg same_value_ff,
  output reg greater_than_ff,
  output reg less_than_ff,
  output reg timeout_error_flag_ff,
  output wire alarm_input_flag
);

  localparam ST_IDLE = 1'b0;
  localparam ST_DIV = 1'b1;

  reg state_ff;
  reg nxt_state;
  reg alarm_meta_ff;
  reg alarm_sync_ff;
  reg div_mod_ff;
  reg div_direct_ff;
  reg [31:0] div_operand_ff;

  // the two types that hand the work to the iterative divider
  function is_div_type;
    input [7:0] ty;
    begin
      is_div_type = (ty == `ACB_ARITH_DIV) || (ty == `ACB_ARITH_MOD);
    end
  endfunction

  // stored steps move the pc; a pc load in the same cycle wins
  function pc_step_ok;
    input direct;
    input load;
    begin
      pc_step_ok = !direct && !load;
    end
  endfunction

  // compare flags as null, same, greater, less on signed values
  function [3:0] cmp_flags;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] d;
    begin
      d = a - b;
      cmp_flags = {(d == 32'h00000000), (a == b), ($signed(a) > $signed(b)), ($signed(a) < $signed(b))};
    end
  endfunction

  // frame bytes arrive most significant first
  wire [7:0] value_byte [0:3];
  wire [31:0] operand;
  genvar gi;

  assign value_byte[3] = cmd_value_b3;
  assign value_byte[2] = cmd_value_b2;
  assign value_byte[1] = cmd_value_b1;
  assign value_byte[0] = cmd_value_b0;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_operand
      assign operand[gi*8 +: 8] = value_byte[gi];
    end
  endgenerate

  // bank byte deliberately unused by all three instructions
  wire take = cmd_valid && cmd_ready;
  wire is_arith = (cmd_opcode == `ACB_OP_ARITH);
  wire is_compare = (cmd_opcode == `ACB_OP_COMPARE);
  wire is_branch = (cmd_opcode == `ACB_OP_BRANCH);
  wire div_kind = is_div_type(cmd_type);
  wire [3:0] cmp_now = cmp_flags(acc_ff, operand);
  // divide by zero leaves the accumulator alone instead of stalling
  wire div_start = take && is_arith && div_kind && (operand != 32'h00000000);
  wire div_done;
  wire [31:0] div_quotient;
  wire [31:0] div_remainder;
  wire branch_true;

  // signed low word of the product; wraps like the accumulator does
  wire [63:0] product = $signed(acc_ff) * $signed(operand);
  wire [31:0] diff = acc_ff - operand;

  assign cmd_ready = (state_ff == ST_IDLE);
  assign alarm_input_flag = alarm_sync_ff;

  acb_divider u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(div_start),
    .dividend(acc_ff),
    .divisor(operand),
    .done_ff(div_done),
    .quotient_ff(div_quotient),
    .remainder_ff(div_remainder)
  );

  acb_cond_eval u_cond (
    .cond_code(cmd_type),
    .null_result(null_result_ff),
    .same_value(same_value_ff),
    .greater_than(greater_than_ff),
    .less_than(less_than_ff),
    .timeout_error_flag(timeout_error_flag_ff),
    .alarm_input_flag(alarm_sync_ff),
    .deviation_error_flag(deviation_error),
    .position_error_flag(position_error),
    .take_branch(branch_true)
  );

  // arithmetic result for single-cycle operations
  reg [31:0] nxt_acc_arith;
  reg arith_known;

  always @* begin
    nxt_acc_arith = acc_ff;
    arith_known = 1'b1;
    case (cmd_type)
      `ACB_ARITH_ADD: nxt_acc_arith = acc_ff + operand;
      `ACB_ARITH_SUB: nxt_acc_arith = diff;
      `ACB_ARITH_MUL: nxt_acc_arith = product[31:0];
      `ACB_ARITH_DIV: nxt_acc_arith = acc_ff;
      `ACB_ARITH_MOD: nxt_acc_arith = acc_ff;
      `ACB_ARITH_AND: nxt_acc_arith = acc_ff & operand;
      `ACB_ARITH_OR: nxt_acc_arith = acc_ff | operand;
      `ACB_ARITH_XOR: nxt_acc_arith = acc_ff ^ operand;
      `ACB_ARITH_NOT: nxt_acc_arith = ~acc_ff;
      `ACB_ARITH_LOAD: nxt_acc_arith = operand;
      default: begin
        nxt_acc_arith = acc_ff;
        arith_known = 1'b0;
      end
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (div_start) begin
          nxt_state = ST_DIV;
        end
      end
      ST_DIV: begin
        if (div_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // external alarm pin crosses into the clock domain
  always @(posedge ref_clk) begin
    if (rst) begin
      alarm_meta_ff <= 1'b0;
      alarm_sync_ff <= 1'b0;
    end else begin
      alarm_meta_ff <= alarm_in;
      alarm_sync_ff <= alarm_meta_ff;
    end
  end

  // set wins over clear so a timeout in the clear cycle survives
  always @(posedge ref_clk) begin
    if (rst) begin
      timeout_error_flag_ff <= 1'b0;
    end else if (wait_timeout) begin
      timeout_error_flag_ff <= 1'b1;
    end else if (error_clear) begin
      timeout_error_flag_ff <= 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      acc_ff <= `ACB_ACC_RST;
      pc_ff <= `ACB_PC_RST;
      null_result_ff <= 1'b0;
      same_value_ff <= 1'b0;
      greater_than_ff <= 1'b0;
      less_than_ff <= 1'b0;
      div_mod_ff <= 1'b0;
      div_direct_ff <= 1'b0;
      div_operand_ff <= 32'h00000000;
      rsp_valid_ff <= 1'b0;
      rsp_status_ff <= 8'h00;
      rsp_opcode_ff <= 8'h00;
      rsp_value_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      rsp_valid_ff <= 1'b0;
      if (pc_load_valid) begin
        pc_ff <= pc_load_data;
      end
      if (state_ff == ST_DIV) begin
        if (div_done) begin
          acc_ff <= div_mod_ff ? div_remainder : div_quotient;
          rsp_valid_ff <= 1'b1;
          rsp_status_ff <= `ACB_STATUS_OK;
          rsp_opcode_ff <= `ACB_OP_ARITH;
          rsp_value_ff <= div_operand_ff;
          if (pc_step_ok(div_direct_ff, pc_load_valid)) begin
            pc_ff <= pc_ff + 32'h00000001;
          end
        end
      end else if (take) begin
        rsp_valid_ff <= 1'b1;
        rsp_opcode_ff <= cmd_opcode;
        rsp_value_ff <= operand;
        rsp_status_ff <= `ACB_STATUS_OK;
        if (is_arith) begin
          if (div_start) begin
            // reply and pc step wait for the divider
            rsp_valid_ff <= 1'b0;
            div_mod_ff <= (cmd_type == `ACB_ARITH_MOD);
            div_direct_ff <= cmd_direct;
            div_operand_ff <= operand;
          end else begin
            acc_ff <= nxt_acc_arith;
            if (!arith_known) begin
              rsp_status_ff <= `ACB_STATUS_BAD_CMD;
            end
            if (pc_step_ok(cmd_direct, pc_load_valid)) begin
              pc_ff <= pc_ff + 32'h00000001;
            end
          end
        end else if (is_compare) begin
          null_result_ff <= cmp_now[3];
          same_value_ff <= cmp_now[2];
          greater_than_ff <= cmp_now[1];
          less_than_ff <= cmp_now[0];
          if (pc_step_ok(cmd_direct, pc_load_valid)) begin
            pc_ff <= pc_ff + 32'h00000001;
          end
        end else if (is_branch) begin
          // pc only moves for stored-program jumps, direct ones just reply
          if (pc_step_ok(cmd_direct, pc_load_valid)) begin
            if (branch_true) begin
              pc_ff <= operand;
            end else begin
              pc_ff <= pc_ff + 32'h00000001;
            end
          end
        end else begin
          rsp_status_ff <= `ACB_STATUS_BAD_CMD;
        end
      end else if (acc_load_valid) begin
        acc_ff <= acc_load_data;
      end
    end
  end

endmodule // acb_unit

//--- include/acb_defines.vh
// constants for the accumulator, compare and branch unit
`ifndef ACB_DEFINES_VH
`define ACB_DEFINES_VH

// datapath widths
`define ACB_DATA_W 32
`define ACB_BYTE_W 8

// instruction numbers
`define ACB_OP_ARITH 8'h13
`define ACB_OP_COMPARE 8'h14
`define ACB_OP_BRANCH 8'h15

// arithmetic operation codes
`define ACB_ARITH_ADD 8'h00
`define ACB_ARITH_SUB 8'h01
`define ACB_ARITH_MUL 8'h02
`define ACB_ARITH_DIV 8'h03
`define ACB_ARITH_MOD 8'h04
`define ACB_ARITH_AND 8'h05
`define ACB_ARITH_OR 8'h06
`define ACB_ARITH_XOR 8'h07
`define ACB_ARITH_NOT 8'h08
`define ACB_ARITH_LOAD 8'h09

// branch condition codes
`define ACB_COND_NULL_RESULT 8'h00
`define ACB_COND_NONNULL_RESULT 8'h01
`define ACB_COND_SAME_VALUE 8'h02
`define ACB_COND_DIFFERS_VALUE 8'h03
`define ACB_COND_GREATER_THAN 8'h04
`define ACB_COND_GREATER_OR_SAME 8'h05
`define ACB_COND_LESS_THAN 8'h06
`define ACB_COND_BELOW_OR_SAME 8'h07
`define ACB_COND_TIMEOUT 8'h08
`define ACB_COND_ALARM 8'h09
`define ACB_COND_DEVIATION 8'h0a
`define ACB_COND_POSITION 8'h0b

// reply status codes
`define ACB_STATUS_OK 8'h64
`define ACB_STATUS_BAD_CMD 8'h02

// reset values
`define ACB_ACC_RST 32'h00000000
`define ACB_PC_RST 32'h00000000

// divider iteration count
`define ACB_DIV_STEPS 6'h20

`endif

//--- verif/acb_host.sv
// host model offering command frames to the unit
module acb_host (
  // clock
  input wire ref_clk,
  // command out
  output logic cmd_valid,
  input wire cmd_ready,
  output logic cmd_direct,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_type,
  output logic [7:0] cmd_bank,
  output logic [31:0] cmd_value,
  // status
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid, cmd_direct, cmd_opcode, cmd_type, cmd_bank, cmd_value, hung} = '0;
  end
  task automatic send(input logic d, input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v);
    int n;
    @(negedge ref_clk);
    {cmd_direct, cmd_opcode, cmd_type, cmd_value} = {d, op, ty, v};
    cmd_bank = ~ty;
    cmd_valid = 1'b1;
    n = 0;
    // ready is looked at settled, before the edge that takes the frame
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    hung = hung | (n == 100);
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_value = ~v;
  endtask
endmodule // acb_host

//--- verif/acb_unit_properties.sv
// concurrent checks on the ports of the accumulator, compare and branch unit
`include "acb_defines.vh"
module acb_unit_properties (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // command
  input wire cmd_valid,
  input wire cmd_ready,
  input wire cmd_direct,
  input wire [7:0] cmd_opcode,
  input wire [7:0] cmd_type,
  input wire [7:0] cmd_value_b3,
  input wire [7:0] cmd_value_b2,
  input wire [7:0] cmd_value_b1,
  input wire [7:0] cmd_value_b0,
  // results and pc load
  input wire rsp_valid_ff,
  input wire [7:0] rsp_status_ff,
  input wire pc_load_valid,
  input wire [31:0] pc_ff,
  input wire [31:0] acc_ff,
  // flags
  input wire wait_timeout,
  input wire error_clear,
  input wire null_result_ff,
  input wire timeout_error_flag_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  wire [31:0] opnd = {cmd_value_b3, cmd_value_b2, cmd_value_b1, cmd_value_b0};
  wire arith = take && (cmd_opcode == `ACB_OP_ARITH);
  // pc load wins over a branch, so it is kept out of the branch checks
  wire jump = take && (cmd_opcode == `ACB_OP_BRANCH) && !cmd_direct && !pc_load_valid
    && (cmd_type == `ACB_COND_NULL_RESULT);
  wire slow = (cmd_type == `ACB_ARITH_DIV) || (cmd_type == `ACB_ARITH_MOD);

  a_add_result: assert property (arith && cmd_type == `ACB_ARITH_ADD |=> acc_ff == $past(acc_ff) + $past(opnd))
    else $error("add result wrong");
  a_xor_result: assert property (arith && cmd_type == `ACB_ARITH_XOR |=> acc_ff == ($past(acc_ff) ^ $past(opnd)))
    else $error("xor result wrong");
  a_not_result: assert property (arith && cmd_type == `ACB_ARITH_NOT |=> acc_ff == ~$past(acc_ff))
    else $error("invert result wrong");
  a_direct_ok: assert property (arith && cmd_direct && cmd_type <= `ACB_ARITH_LOAD && !slow
    |=> rsp_valid_ff && rsp_status_ff == `ACB_STATUS_OK) else $error("direct reply wrong");
  a_divide_latency: assert property (arith && slow && opnd != 32'h0 |=> !cmd_ready ##33 rsp_valid_ff)
    else $error("divide timing wrong");
  a_compare_reply: assert property (take && cmd_opcode == `ACB_OP_COMPARE |=> rsp_valid_ff && $stable(acc_ff))
    else $error("compare reply wrong");
  a_branch_taken: assert property (jump && null_result_ff |=> pc_ff == $past(opnd))
    else $error("branch not taken");
  a_branch_skip: assert property (jump && !null_result_ff |=> pc_ff == $past(pc_ff) + 32'h1 && $stable(acc_ff))
    else $error("false branch wrong");
  a_timeout_set: assert property (wait_timeout |=> timeout_error_flag_ff)
    else $error("timeout flag not set");
  a_timeout_hold: assert property (timeout_error_flag_ff && !error_clear |=> timeout_error_flag_ff)
    else $error("timeout flag lost");
endmodule // acb_unit_properties

bind acb_unit acb_unit_properties i_acb_unit_properties (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_direct(cmd_direct), .cmd_opcode(cmd_opcode), .cmd_type(cmd_type),
  .cmd_value_b3(cmd_value_b3), .cmd_value_b2(cmd_value_b2), .cmd_value_b1(cmd_value_b1),
  .cmd_value_b0(cmd_value_b0), .rsp_valid_ff(rsp_valid_ff), .rsp_status_ff(rsp_status_ff),
  .pc_load_valid(pc_load_valid), .pc_ff(pc_ff), .acc_ff(acc_ff), .wait_timeout(wait_timeout),
  .error_clear(error_clear), .null_result_ff(null_result_ff), .timeout_error_flag_ff(timeout_error_flag_ff));

//--- verif/tb_accumulator_compare_branch_unit.sv
// self-checking bench for the accumulator, compare and branch unit
`include "acb_defines.vh"
module tb_accumulator_compare_branch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic acc_load_valid = 1'b0, pc_load_valid = 1'b0, wait_timeout = 1'b0, error_clear = 1'b0;
  logic alarm_in = 1'b0, deviation_error = 1'b0, position_error = 1'b0;
  logic [31:0] acc_load_data = 32'h0, pc_load_data = 32'h0;
  wire cmd_valid, cmd_ready, cmd_direct, rsp_valid_ff, hung, null_result_ff, same_value_ff;
  wire greater_than_ff, less_than_ff, timeout_error_flag_ff, alarm_input_flag;
  wire [7:0] cmd_opcode, cmd_type, cmd_bank, rsp_status_ff, rsp_opcode_ff;
  wire [31:0] cmd_value, rsp_value_ff, pc_ff, acc_ff;
  int failures = 0;
  int n_tests = 0;
  logic signed [31:0] m;

  acb_host i_acb_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_direct(cmd_direct),
    .cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value), .hung(hung));
  acb_unit i_acb_unit (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_direct(cmd_direct), .cmd_opcode(cmd_opcode), .cmd_type(cmd_type), .cmd_bank(cmd_bank),
    .cmd_value_b3(cmd_value[31:24]), .cmd_value_b2(cmd_value[23:16]),
    .cmd_value_b1(cmd_value[15:8]), .cmd_value_b0(cmd_value[7:0]), .rsp_valid_ff(rsp_valid_ff),
    .rsp_status_ff(rsp_status_ff), .rsp_opcode_ff(rsp_opcode_ff), .rsp_value_ff(rsp_value_ff),
    .acc_load_valid(acc_load_valid), .acc_load_data(acc_load_data), .pc_load_valid(pc_load_valid),
    .pc_load_data(pc_load_data), .pc_ff(pc_ff), .acc_ff(acc_ff), .wait_timeout(wait_timeout),
    .error_clear(error_clear), .alarm_in(alarm_in), .deviation_error(deviation_error),
    .position_error(position_error), .null_result_ff(null_result_ff), .same_value_ff(same_value_ff),
    .greater_than_ff(greater_than_ff), .less_than_ff(less_than_ff),
    .timeout_error_flag_ff(timeout_error_flag_ff), .alarm_input_flag(alarm_input_flag));

  task automatic test_done;
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one frame, then wait for its reply; divide replies come late
  task automatic do_cmd(input logic d, input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v);
    int n;
    i_acb_host.send(d, op, ty, v);
    n = 0;
    while (rsp_valid_ff !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 60 || hung) begin
      failures++;
      test_done();
    end
  endtask
  task automatic br(input logic [7:0] code, input logic tk);
    logic [31:0] p, a;
    p = pc_ff;
    a = acc_ff;
    do_cmd(1'b0, `ACB_OP_BRANCH, code, 32'h100 + code);
    chk(pc_ff, tk ? 32'h100 + code : p + 32'h1);
    chk(acc_ff, a);
  endtask

  task automatic t_arith;
    logic [31:0] ops [10];
    logic [31:0] p;
    ops = '{32'h1234, 32'h34, 32'hfffffffb, 32'h7, 32'h64, 32'hffff00ff, 32'h00f0000f, 32'h5a5a5a5a, 32'h0, 32'h80000001};
    m = 0;
    for (int k = 0; k < 10; k++) begin
      case (k)
        0: m = m + ops[k];
        1: m = m - ops[k];
        2: m = m * ops[k];
        3: m = m / $signed(ops[k]);
        4: m = m % $signed(ops[k]);
        5: m = m & ops[k];
        6: m = m | ops[k];
        7: m = m ^ ops[k];
        8: m = ~m;
        default: m = ops[k];
      endcase
      do_cmd(1'b1, `ACB_OP_ARITH, 8'(k), ops[k]);
      chk(acc_ff, m);
      chk({24'h0, rsp_status_ff}, {24'h0, `ACB_STATUS_OK});
      chk(rsp_value_ff, ops[k]);
      chk({24'h0, rsp_opcode_ff}, {24'h0, `ACB_OP_ARITH});
    end
    do_cmd(1'b1, `ACB_OP_ARITH, 8'h0a, 32'h5);
    chk({24'h0, rsp_status_ff}, {24'h0, `ACB_STATUS_BAD_CMD});
    chk(acc_ff, m);
    // stored steps: modulo by zero keeps the accumulator, a real divide runs long
    p = pc_ff;
    do_cmd(1'b0, `ACB_OP_ARITH, `ACB_ARITH_MOD, 32'h0);
    chk(acc_ff, m);
    m = m / 32'shfffffffd;
    do_cmd(1'b0, `ACB_OP_ARITH, `ACB_ARITH_DIV, 32'hfffffffd);
    chk(acc_ff, m);
    chk(pc_ff, p + 32'h2);
  endtask

  task automatic t_branch;
    logic [31:0] cv [3];
    logic signed [31:0] c;
    logic tk;
    logic [3:0] f;
    cv = '{32'h10, 32'h20, 32'hfffffff0};
    do_cmd(1'b1, `ACB_OP_ARITH, `ACB_ARITH_LOAD, 32'h10);
    for (int i = 0; i < 3; i++) begin
      c = cv[i];
      do_cmd(1'b0, `ACB_OP_COMPARE, 8'h00, cv[i]);
      f = {c == 32'sh10, c == 32'sh10, 32'sh10 > c, 32'sh10 < c};
      chk({28'h0, null_result_ff, same_value_ff, greater_than_ff, less_than_ff}, {28'h0, f});
      for (int k = 0; k < 8; k++) begin
        case (k)
          0, 2: tk = (c == 32'sh10);
          1, 3: tk = (c != 32'sh10);
          4: tk = (32'sh10 > c);
          5: tk = (32'sh10 >= c);
          6: tk = (32'sh10 < c);
          default: tk = (32'sh10 <= c);
        endcase
        br(8'(k), tk);
      end
    end
  endtask

  task automatic t_flags;
    @(negedge ref_clk);
    wait_timeout = 1'b1;
    @(negedge ref_clk);
    wait_timeout = 1'b0;
    br(`ACB_COND_TIMEOUT, 1'b1);
    br(`ACB_COND_TIMEOUT, 1'b1);
    error_clear = 1'b1;
    @(negedge ref_clk);
    error_clear = 1'b0;
    br(`ACB_COND_TIMEOUT, 1'b0);
    alarm_in = 1'b1;
    // alarm pin passes a two-stage synchroniser first
    repeat (3) @(negedge ref_clk);
    chk({31'h0, alarm_input_flag}, 32'h1);
    br(`ACB_COND_ALARM, 1'b1);
    alarm_in = 1'b0;
    deviation_error = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({31'h0, alarm_input_flag}, 32'h0);
    br(`ACB_COND_ALARM, 1'b0);
    br(`ACB_COND_DEVIATION, 1'b1);
    deviation_error = 1'b0;
    position_error = 1'b1;
    br(`ACB_COND_DEVIATION, 1'b0);
    br(`ACB_COND_POSITION, 1'b1);
    position_error = 1'b0;
    br(`ACB_COND_POSITION, 1'b0);
  endtask

  task automatic t_misc;
    @(negedge ref_clk);
    {acc_load_valid, acc_load_data, pc_load_valid, pc_load_data} = {1'b1, 32'h0bad0123, 1'b1, 32'h40};
    @(negedge ref_clk);
    {acc_load_valid, pc_load_valid} = 2'b00;
    chk(acc_ff, 32'h0bad0123);
    chk(pc_ff, 32'h40);
    do_cmd(1'b0, 8'h7f, 8'h00, 32'h1);
    chk({24'h0, rsp_status_ff}, {24'h0, `ACB_STATUS_BAD_CMD});
    chk(acc_ff, 32'h0bad0123);
  endtask

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_arith();
    t_branch();
    t_flags();
    t_misc();
    test_done();
  end
endmodule // tb_accumulator_compare_branch_unit
